// >>> inc/tlo_pkg.sv
// shared constants for the temperature limit output block
package tlo_pkg;

    // apb register byte offsets
    localparam logic [7:0] TLO_CTRL_OFS = 8'h00;
    localparam logic [7:0] TLO_CYCLE_OFS = 8'h04;
    localparam logic [7:0] TLO_FIXTHR_OFS = 8'h08;
    localparam logic [7:0] TLO_MDIFF_OFS = 8'h0C;
    localparam logic [7:0] TLO_STATE_OFS = 8'h10;
    localparam logic [7:0] TLO_MEAS_OFS = 8'h14;
    localparam logic [7:0] TLO_IRQST_OFS = 8'h18;
    localparam logic [7:0] TLO_IRQMSK_OFS = 8'h1C;

    // control and cycle register field positions
    localparam int TLO_CTRL_SRC_LSB = 0;
    localparam int TLO_CTRL_SOC_BIT = 2;
    localparam int TLO_CTRL_SUP1_BIT = 3;
    localparam int TLO_CTRL_SUP0_BIT = 4;
    localparam int TLO_CTRL_HYS_LSB = 8;
    localparam int TLO_CTRL_OND_LSB = 12;
    localparam int TLO_CTRL_OFFD_LSB = 16;
    localparam int TLO_CYC_MEAS_LSB = 8;

    // reset values
    localparam logic [31:0] TLO_CTRL_RST = 32'h0000_0004;
    localparam logic [6:0] TLO_CYC_RST = 7'h00;
    localparam logic [15:0] TLO_FIXTHR_RST = 16'h07D0;
    localparam logic [15:0] TLO_MDIFF_RST = 16'h0064;
    localparam logic [3:0] TLO_IRQ_RST = 4'h0;

    // interrupt status bits
    localparam int TLO_IRQ_LIMTX = 0;
    localparam int TLO_IRQ_LIMCHG = 1;
    localparam int TLO_IRQ_EXTTHR = 2;
    localparam int TLO_IRQ_MEASTX = 3;

    // time figures
    localparam int TLO_CLK_HZ = 250_000_000;
    localparam int TLO_CYC_STEP_S = 10;
    localparam int TLO_CYC_MAX = 120;

    // percentage mapping: 0 % -> -20 C, 100 % -> 55 C, in 0.01 C
    localparam int TLO_PCT_LO_C = -2000;
    localparam int TLO_PCT_SPAN_C = 7500;
    localparam int TLO_PCT_FULL = 255;

    // threshold source selection
    typedef enum logic [1:0] {
        TLO_SRC_FIXED,
        TLO_SRC_EXT16,
        TLO_SRC_EXT8,
        TLO_SRC_TEACH
    } tlo_src_t;

    // delay settings in seconds: none, 1, 3, 5, 10, 15, 30 s, 1, 3, 5, 10, 15, 30, 60 min
    function automatic logic [11:0] tlo_delay_s(input logic [3:0] sel);
        logic [11:0] s;
        s = 12'h000;
        case (sel)
            4'h0: s = 12'h000;
            4'h1: s = 12'h001;
            4'h2: s = 12'h003;
            4'h3: s = 12'h005;
            4'h4: s = 12'h00A;
            4'h5: s = 12'h00F;
            4'h6: s = 12'h01E;
            4'h7: s = 12'h03C;
            4'h8: s = 12'h0B4;
            4'h9: s = 12'h12C;
            4'hA: s = 12'h258;
            4'hB: s = 12'h384;
            4'hC: s = 12'h708;
            4'hD: s = 12'hE10;
            default: s = 12'hE10;
        endcase
        return s;
    endfunction

    // hysteresis settings in 0.01 K: none, 1..5, 10, 15, 20 K
    function automatic logic [11:0] tlo_hys_c(input logic [3:0] sel);
        logic [11:0] h;
        h = 12'h000;
        case (sel)
            4'h0: h = 12'h000;
            4'h1: h = 12'h064;
            4'h2: h = 12'h0C8;
            4'h3: h = 12'h12C;
            4'h4: h = 12'h190;
            4'h5: h = 12'h1F4;
            4'h6: h = 12'h3E8;
            4'h7: h = 12'h5DC;
            4'h8: h = 12'h7D0;
            default: h = 12'h7D0;
        endcase
        return h;
    endfunction

endpackage

// >>> design/tlo_top.sv
// temperature limit output: threshold select, hysteresis, delays, telegram send
// Notes on behaviour
// - threshold source fixed, 16-bit or 8-bit external, or teach
// - rising state accepted after switch-on delay
// - cyclic sends keep zero during on-delay
// - falling state accepted after switch-off delay
// - cyclic sends keep one during off-delay
// - no-telegram condition also suppresses cyclic sends
// - send-on-change off: no send on change
// - send-on-change on: send every accepted transition
// - cyclic setting nonzero sends periodically regardless
// - cyclic period is setting times ten seconds
// - cyclic setting zero disables periodic sends
// - both off: limit output never sent
// - measured temperature float object, on difference/cyclic
// - one-bit limit output with own delays
// - external float value written becomes threshold
// - percent byte maps linearly -20 to 55 C
// - hysteresis up to 20 K separates set/clear
// - teach rising edge stores measurement as threshold
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tlo_top
    import tlo_pkg::*;
#(
    parameter int CLK_HZ = tlo_pkg::TLO_CLK_HZ
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurement from the sensor front end, 0.01 C signed
    input wire logic meas_valid,
    input wire logic [15:0] meas_value,
    // received bus objects
    input wire logic ext16_valid,
    input wire logic [15:0] ext16_data,
    input wire logic ext8_valid,
    input wire logic [7:0] ext8_data,
    input wire logic teach_valid,
    input wire logic teach_bit,
    // transmitted bus objects
    output logic lim_tx,
    output logic lim_tx_value,
    output logic meas_tx,
    output logic [15:0] meas_tx_float,
    // interrupt
    output logic irq
);
    import tlo_pkg::*;

    localparam int SEC_CYC = (CLK_HZ < 1) ? 1 : CLK_HZ;

    // reset release synchroniser
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // float helpers: 2-byte bus float is 0.01 * M * 2^E, M 12-bit two's complement
    function automatic logic [15:0] float_to_centi(input logic [15:0] f);
        logic signed [31:0] m;
        logic signed [31:0] v;
        m = 32'(signed'({f[15], f[10:0]}));
        v = m <<< f[14:11];
        if (v > 32'sd32767) begin
            v = 32'sd32767;
        end else if (v < -32'sd32768) begin
            v = -32'sd32768;
        end
        return v[15:0];
    endfunction

    function automatic logic [15:0] centi_to_float(input logic [15:0] c);
        logic signed [15:0] v;
        logic signed [15:0] m;
        logic [3:0] e;
        logic done;
        v = signed'(c);
        m = v;
        e = 4'h0;
        done = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (!done && (v >>> i) <= 16'sd2047 && (v >>> i) >= -16'sd2048) begin
                m = v >>> i;
                e = 4'(i);
                done = 1'b1;
            end
        end
        return {m[15], e, m[10:0]};
    endfunction

    // apb decode
    wire acc_start = psel && penable && !pready;
    wire wr_en = acc_start && pwrite;
    wire rd_en = acc_start && !pwrite;
    wire a_ctrl = paddr == TLO_CTRL_OFS;
    wire a_cycle = paddr == TLO_CYCLE_OFS;
    wire a_fix = paddr == TLO_FIXTHR_OFS;
    wire a_mdiff = paddr == TLO_MDIFF_OFS;
    wire a_state = paddr == TLO_STATE_OFS;
    wire a_meas = paddr == TLO_MEAS_OFS;
    wire a_irqst = paddr == TLO_IRQST_OFS;
    wire a_irqmsk = paddr == TLO_IRQMSK_OFS;
    wire a_hit = a_ctrl | a_cycle | a_fix | a_mdiff | a_state | a_meas | a_irqst | a_irqmsk;

    // configuration registers
    logic [31:0] ctrl_q;
    logic [6:0] lim_cyc_q;
    logic [6:0] meas_cyc_q;
    logic [15:0] fix_thr_q;
    logic [15:0] mdiff_q;
    logic [3:0] irq_mask_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= TLO_CTRL_RST;
            lim_cyc_q <= TLO_CYC_RST;
            meas_cyc_q <= TLO_CYC_RST;
            fix_thr_q <= TLO_FIXTHR_RST;
            mdiff_q <= TLO_MDIFF_RST;
            irq_mask_q <= TLO_IRQ_RST;
        end else if (wr_en) begin
            if (a_ctrl) begin
                ctrl_q <= {12'h000, pwdata[19:8], 3'b000, pwdata[4:0]};
            end
            if (a_cycle) begin
                lim_cyc_q <= pwdata[6:0];
                meas_cyc_q <= pwdata[TLO_CYC_MEAS_LSB +: 7];
            end
            if (a_fix) begin
                fix_thr_q <= pwdata[15:0];
            end
            if (a_mdiff) begin
                mdiff_q <= pwdata[15:0];
            end
            if (a_irqmsk) begin
                irq_mask_q <= pwdata[3:0];
            end
        end
    end

    wire tlo_src_t src = tlo_src_t'(ctrl_q[TLO_CTRL_SRC_LSB +: 2]);
    wire send_chg = ctrl_q[TLO_CTRL_SOC_BIT];
    wire sup_one = ctrl_q[TLO_CTRL_SUP1_BIT];
    wire sup_zero = ctrl_q[TLO_CTRL_SUP0_BIT];
    wire [11:0] hys_c = tlo_hys_c(ctrl_q[TLO_CTRL_HYS_LSB +: 4]);
    wire [11:0] on_dly_s = tlo_delay_s(ctrl_q[TLO_CTRL_OND_LSB +: 4]);
    wire [11:0] off_dly_s = tlo_delay_s(ctrl_q[TLO_CTRL_OFFD_LSB +: 4]);
    // values above the documented maximum are clipped so the period stays bounded
    wire [6:0] lim_cyc = (lim_cyc_q > 7'(TLO_CYC_MAX)) ? 7'(TLO_CYC_MAX) : lim_cyc_q;
    wire [6:0] meas_cyc = (meas_cyc_q > 7'(TLO_CYC_MAX)) ? 7'(TLO_CYC_MAX) : meas_cyc_q;
    wire [10:0] lim_per_s = 11'(lim_cyc * TLO_CYC_STEP_S);
    wire [10:0] meas_per_s = 11'(meas_cyc * TLO_CYC_STEP_S);

    // one-second enable
    logic [31:0] pre_q;
    logic sec_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 32'h0000_0000;
            sec_q <= 1'b0;
        end else if (pre_q == 32'(SEC_CYC - 1)) begin
            pre_q <= 32'h0000_0000;
            sec_q <= 1'b1;
        end else begin
            pre_q <= pre_q + 32'h0000_0001;
            sec_q <= 1'b0;
        end
    end

    // measurement store
    logic [15:0] meas_q;
    logic meas_seen_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meas_q <= 16'h0000;
            meas_seen_q <= 1'b0;
        end else if (meas_valid) begin
            meas_q <= meas_value;
            meas_seen_q <= 1'b1;
        end
    end

    // external threshold: percent byte scaled with p*7500/255 = p*500/17
    wire [17:0] pct_prod = 18'(ext8_data * 10'd500);
    wire [17:0] pct_quot = pct_prod / 18'd17;
    wire [15:0] pct_centi = 16'(TLO_PCT_LO_C) + pct_quot[15:0];
    wire [15:0] ext16_centi = float_to_centi(ext16_data);
    logic teach_prev_q;
    wire teach_rise = teach_valid && teach_bit && !teach_prev_q;
    wire ext_wr = (src == TLO_SRC_EXT16 && ext16_valid) || (src == TLO_SRC_EXT8 && ext8_valid)
        || (src == TLO_SRC_TEACH && teach_rise);

    logic [15:0] ext_thr_q;
    logic ext_set_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_thr_q <= TLO_FIXTHR_RST;
            ext_set_q <= 1'b0;
            teach_prev_q <= 1'b0;
        end else begin
            if (teach_valid) begin
                teach_prev_q <= teach_bit;
            end
            if (src == TLO_SRC_EXT16 && ext16_valid) begin
                ext_thr_q <= ext16_centi;
                ext_set_q <= 1'b1;
            end else if (src == TLO_SRC_EXT8 && ext8_valid) begin
                ext_thr_q <= pct_centi;
                ext_set_q <= 1'b1;
            end else if (src == TLO_SRC_TEACH && teach_rise) begin
                ext_thr_q <= meas_q;
                ext_set_q <= 1'b1;
            end
        end
    end

    // until an external value arrives the fixed threshold applies
    wire use_fixed = (src == TLO_SRC_FIXED) || !ext_set_q;
    wire [15:0] thr = use_fixed ? fix_thr_q : ext_thr_q;

    // raw limit with hysteresis; evaluated every cycle so any new data is seen
    wire signed [17:0] meas_s = 18'(signed'(meas_q));
    wire signed [17:0] thr_s = 18'(signed'(thr));
    wire signed [17:0] clr_s = thr_s - signed'({6'h00, hys_c});
    wire raw_set = meas_seen_q && (meas_s >= thr_s);
    wire raw_clr = meas_s < clr_s;
    logic raw_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_q <= 1'b0;
        end else if (!raw_q && raw_set) begin
            raw_q <= 1'b1;
        end else if (raw_q && raw_clr) begin
            raw_q <= 1'b0;
        end
    end

    // delay timer: restarts on every raw change, accepts after delay + 1 tick
    logic out_q;
    logic raw_prev_q;
    logic [11:0] dly_cnt_q;
    wire pend = raw_q != out_q;
    wire raw_chg = raw_q != raw_prev_q;
    wire [11:0] dly_s = raw_q ? on_dly_s : off_dly_s;
    wire dly_done = (dly_s == 12'h000) || (sec_q && dly_cnt_q >= dly_s);
    wire accept = pend && dly_done;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 1'b0;
            raw_prev_q <= 1'b0;
            dly_cnt_q <= 12'h000;
        end else begin
            raw_prev_q <= raw_q;
            if (raw_chg || !pend) begin
                dly_cnt_q <= 12'h000;
            end else if (sec_q && dly_cnt_q != 12'hFFF) begin
                dly_cnt_q <= dly_cnt_q + 12'h001;
            end
            if (accept) begin
                out_q <= raw_q;
            end
        end
    end

    // limit telegram scheduling; the sent value is always the accepted state
    wire suppress = out_q ? sup_one : sup_zero;
    logic [10:0] lim_sec_q;
    wire lim_cyc_due = (lim_cyc != 7'h00) && sec_q && (lim_sec_q + 11'h001 >= lim_per_s);
    wire chg_send = accept && send_chg && !(raw_q ? sup_one : sup_zero);
    wire cyc_send = lim_cyc_due && !suppress;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lim_sec_q <= 11'h000;
            lim_tx <= 1'b0;
            lim_tx_value <= 1'b0;
        end else begin
            if (lim_cyc == 7'h00 || lim_cyc_due) begin
                lim_sec_q <= 11'h000;
            end else if (sec_q) begin
                lim_sec_q <= lim_sec_q + 11'h001;
            end
            lim_tx <= chg_send || cyc_send;
            if (chg_send) begin
                lim_tx_value <= raw_q;
            end else if (cyc_send) begin
                lim_tx_value <= out_q;
            end
        end
    end

    // measured value object: on difference and/or cyclically
    logic [15:0] meas_last_q;
    logic [10:0] meas_sec_q;
    wire signed [17:0] mdelta = 18'(signed'(meas_value)) - 18'(signed'(meas_last_q));
    wire [17:0] mabs = mdelta[17] ? 18'(-mdelta) : 18'(mdelta);
    wire meas_diff = meas_valid && (mdiff_q != 16'h0000) && (mabs >= {2'b00, mdiff_q});
    wire meas_cyc_due = (meas_cyc != 7'h00) && sec_q && meas_seen_q
        && (meas_sec_q + 11'h001 >= meas_per_s);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meas_last_q <= 16'h0000;
            meas_sec_q <= 11'h000;
            meas_tx <= 1'b0;
            meas_tx_float <= 16'h0000;
        end else begin
            if (meas_cyc == 7'h00 || meas_cyc_due) begin
                meas_sec_q <= 11'h000;
            end else if (sec_q) begin
                meas_sec_q <= meas_sec_q + 11'h001;
            end
            meas_tx <= meas_diff || meas_cyc_due;
            if (meas_diff) begin
                meas_last_q <= meas_value;
                meas_tx_float <= centi_to_float(meas_value);
            end else if (meas_cyc_due) begin
                meas_last_q <= meas_q;
                meas_tx_float <= centi_to_float(meas_q);
            end
        end
    end

    // interrupt status, write one to clear, a new event beats the clear
    logic [3:0] irq_st_q;
    wire [3:0] irq_ev = {meas_diff | meas_cyc_due, ext_wr, accept, chg_send | cyc_send};
    wire [3:0] irq_clr = (wr_en && a_irqst) ? pwdata[3:0] : 4'h0;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_st_q <= TLO_IRQ_RST;
            irq <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
            irq <= |(((irq_st_q & ~irq_clr) | irq_ev) & irq_mask_q);
        end
    end

    // read mux
    wire [31:0] state_word = {thr, 12'h000, dly_cnt_q != 12'h000, pend, out_q, raw_q};
    wire [31:0] rd_mux = a_ctrl ? ctrl_q
        : a_cycle ? {17'h00000, meas_cyc_q, 1'b0, lim_cyc_q}
        : a_fix ? {16'h0000, fix_thr_q}
        : a_mdiff ? {16'h0000, mdiff_q}
        : a_state ? state_word
        : a_meas ? {15'h0000, meas_seen_q, meas_q}
        : a_irqst ? {28'h0000000, irq_st_q}
        : a_irqmsk ? {28'h0000000, irq_mask_q}
        : 32'h0000_0000;

    // one wait state: answer is registered on the first access cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc_start;
            pslverr <= acc_start && !a_hit;
            prdata <= (rd_en && a_hit) ? rd_mux : 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// >>> sim/tlo_props.sv
// checker for the temperature limit output ports
`timescale 1ns/100ps
`default_nettype none
module tlo_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // telegrams
    input wire logic lim_tx,
    input wire logic lim_tx_value,
    input wire logic meas_tx
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire logic acc = psel && penable && !pready;

    AST_PREADY_ONE_WAIT: assert property (acc |=> pready) else $error("pready late");
    AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready held");
    AST_ERR_UNMAPPED: assert property (acc && paddr > 8'h1C |=> pslverr)
        else $error("no error on unmapped");
    AST_NO_ERR_MAPPED: assert property (acc && paddr <= 8'h1C && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("error on mapped");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("lone pslverr");
    AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
    AST_LIM_PULSE: assert property (lim_tx |=> !lim_tx) else $error("lim_tx held");
    AST_LIM_VALUE_HOLD: assert property (!lim_tx |-> $stable(lim_tx_value))
        else $error("value moved without send");
    AST_MEAS_PULSE: assert property (meas_tx |=> !meas_tx) else $error("meas_tx held");

    cover property (lim_tx && lim_tx_value);
    cover property (lim_tx && !lim_tx_value);
    cover property (pslverr);
endmodule
bind tlo_top tlo_props u_props (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lim_tx(lim_tx), .lim_tx_value(lim_tx_value), .meas_tx(meas_tx));
`default_nettype wire

// >>> sim/tlo_bus_model.sv
// bus partner model: writes objects into the device, counts limit telegrams
`timescale 1ns/100ps
`default_nettype none
module tlo_bus_model (
    // clock
    input wire logic sys_clk,
    // objects written by other devices
    output logic meas_valid,
    output logic [15:0] meas_value,
    output logic ext16_valid,
    output logic [15:0] ext16_data,
    output logic ext8_valid,
    output logic [7:0] ext8_data,
    // telegrams from the device
    input wire logic lim_tx,
    input wire logic lim_tx_value
);
    int n_one = 0;
    int n_zero = 0;
    initial begin
        {meas_valid, ext16_valid, ext8_valid} = 3'h0;
        {meas_value, ext16_data, ext8_data} = 40'h0;
    end
    always @(posedge sys_clk) begin
        if (lim_tx) begin
            if (lim_tx_value)
                n_one <= n_one + 1;
            else
                n_zero <= n_zero + 1;
        end
    end
    // k: 0 measurement, 1 two-byte threshold, 2 percent threshold
    task automatic put(input int k, input logic [15:0] d);
        @(posedge sys_clk);
        meas_valid <= (k == 0);
        ext16_valid <= (k == 1);
        ext8_valid <= (k == 2);
        {meas_value, ext16_data, ext8_data} <= {d, d, d[7:0]};
        @(posedge sys_clk);
        {meas_valid, ext16_valid, ext8_valid} <= 3'h0;
        // released data must not look valid by accident
        {meas_value, ext16_data, ext8_data} <= ~{d, d, d[7:0]};
    endtask
endmodule
`default_nettype wire

// >>> sim/temperature_limit_output_tb.sv
// self-checking bench for the temperature limit output
`timescale 1ns/100ps
`default_nettype none
module temperature_limit_output_tb;
    import tlo_pkg::*;
    localparam int HZ = 20;
    typedef struct {logic [15:0] m; logic v;} tlo_row_t;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, meas_valid, ext16_valid, ext8_valid, err;
    logic lim_tx, lim_tx_value, meas_tx, irq;
    logic [15:0] meas_value, ext16_data;
    logic [7:0] ext8_data;
    logic [15:0] mtf;
    logic teach_valid = 1'b0;
    logic teach_bit = 1'b0;
    int err_total = 0;
    int n_compared = 0;
    int c, ob, zb;
    tlo_row_t rows [4] = '{'{16'h07D0, 1'b1}, '{16'h07CF, 1'b0}, '{16'h1388, 1'b1},
        '{16'hFED4, 1'b0}};
    int pv [3] = '{0, 128, 255};
    logic [7:0] ofs [6] = '{TLO_CTRL_OFS, TLO_CYCLE_OFS, TLO_FIXTHR_OFS, TLO_MDIFF_OFS,
        TLO_IRQST_OFS, TLO_IRQMSK_OFS};
    logic [31:0] rst [6] = '{TLO_CTRL_RST, 32'(TLO_CYC_RST), 32'(TLO_FIXTHR_RST),
        32'(TLO_MDIFF_RST), 32'(TLO_IRQ_RST), 32'(TLO_IRQ_RST)};

    always #2 sys_clk = ~sys_clk;

    tlo_top #(.CLK_HZ(HZ)) DUT (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas_valid(meas_valid), .meas_value(meas_value),
        .ext16_valid(ext16_valid), .ext16_data(ext16_data), .ext8_valid(ext8_valid),
        .ext8_data(ext8_data), .teach_valid(teach_valid), .teach_bit(teach_bit),
        .lim_tx(lim_tx), .lim_tx_value(lim_tx_value), .meas_tx(meas_tx), .meas_tx_float(mtf),
        .irq(irq));
    tlo_bus_model u_bus (.sys_clk(sys_clk), .meas_valid(meas_valid), .meas_value(meas_value),
        .ext16_valid(ext16_valid), .ext16_data(ext16_data), .ext8_valid(ext8_valid),
        .ext8_data(ext8_data), .lim_tx(lim_tx), .lim_tx_value(lim_tx_value));

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the slave
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, rd & m, e);
    endtask
    task automatic wait_tx(input int lim);
        int b;
        b = u_bus.n_one + u_bus.n_zero;
        c = 0;
        while (u_bus.n_one + u_bus.n_zero == b && c < lim) begin
            @(posedge sys_clk);
            c++;
        end
        chk("tx wait", c < lim, 1);
    endtask
    // the old value keeps going out cyclically until the delay has run out
    task automatic dly(input logic [31:0] ctrl, input logic [15:0] m, input logic nv);
        apb(1'b1, TLO_CTRL_OFS, ctrl);
        {ob, zb} = {u_bus.n_one, u_bus.n_zero};
        u_bus.put(0, m);
        repeat (1180) @(posedge sys_clk);
        chk("early new", nv ? u_bus.n_one - ob : u_bus.n_zero - zb, 0);
        chk("old cyclic", (nv ? u_bus.n_zero - zb : u_bus.n_one - ob) >= 5, 1);
        repeat (80) @(posedge sys_clk);
        chk("late new", (nv ? u_bus.n_one - ob : u_bus.n_zero - zb) > 0, 1);
    endtask
    task automatic quiet(input logic [31:0] ctrl, input logic [15:0] m, input logic nv);
        apb(1'b1, TLO_CTRL_OFS, ctrl);
        ob = nv ? u_bus.n_one : u_bus.n_zero;
        u_bus.put(0, m);
        repeat (450) @(posedge sys_clk);
        chk("muted sends", (nv ? u_bus.n_one : u_bus.n_zero) - ob, 0);
        rchk("muted out", TLO_STATE_OFS, 32'h2, {30'h0, nv, 1'b0});
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        final_report;
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        foreach (rows[i]) begin
            u_bus.put(0, rows[i].m);
            wait_tx(20);
            chk("lim value", lim_tx_value, rows[i].v);
            rchk("state out", TLO_STATE_OFS, 32'h2, {30'h0, rows[i].v, 1'b0});
        end
        $display("threshold rows done");
        apb(1'b1, TLO_CYCLE_OFS, 32'h1);
        wait_tx(300);
        wait_tx(300);
        chk("cycle period", c, 10 * HZ);
        dly(32'h0000_7004, 16'h09C4, 1'b1);
        dly(32'h0007_0004, 16'h0000, 1'b0);
        $display("delay cases done");
        quiet(32'h0000_000C, 16'h09C4, 1'b1);
        apb(1'b1, TLO_CYCLE_OFS, 32'h0);
        quiet(32'h0, 16'h0000, 1'b0);
        $display("suppression done");
        apb(1'b1, TLO_CTRL_OFS, 32'h5);
        u_bus.put(1, 16'h0DDC);
        rchk("ext16 thr", TLO_STATE_OFS, 32'hFFFF_0000, 32'h0BB8_0000);
        u_bus.put(2, 16'h00FF);
        rchk("ext8 refused", TLO_STATE_OFS, 32'hFFFF_0000, 32'h0BB8_0000);
        apb(1'b1, TLO_CTRL_OFS, 32'h6);
        foreach (pv[i]) begin
            u_bus.put(2, 16'(pv[i]));
            rchk("ext8 thr", TLO_STATE_OFS, 32'hFFFF_0000,
                {16'(TLO_PCT_LO_C + pv[i] * TLO_PCT_SPAN_C / TLO_PCT_FULL), 16'h0});
        end
        $display("threshold sources done");
        apb(1'b1, TLO_CTRL_OFS, 32'h4);
        apb(1'b1, TLO_IRQST_OFS, 32'hF);
        apb(1'b1, TLO_IRQMSK_OFS, 32'h1);
        u_bus.put(0, 16'h1F40);
        wait_tx(20);
        repeat (3) @(posedge sys_clk);
        chk("irq on", irq, 1);
        rchk("irq status", TLO_IRQST_OFS, 32'h1, 32'h1);
        apb(1'b1, TLO_IRQST_OFS, 32'h1);
        repeat (3) @(posedge sys_clk);
        chk("irq cleared", irq, 0);
        apb(1'b1, TLO_IRQMSK_OFS, 32'h0);
        u_bus.put(0, 16'h0000);
        wait_tx(20);
        repeat (3) @(posedge sys_clk);
        chk("irq masked", irq, 0);
        rchk("irq status masked", TLO_IRQST_OFS, 32'h1, 32'h1);
        $display("interrupt done");
        apb(1'b1, TLO_CTRL_OFS, 32'h7);
        u_bus.put(0, 16'h0BB8);
        @(posedge sys_clk);
        chk("meas float", mtf, 32'h0DDC);
        {teach_valid, teach_bit} <= 2'b11;
        @(posedge sys_clk);
        teach_valid <= 1'b0;
        rchk("teach thr", TLO_STATE_OFS, 32'hFFFF_0000, 32'h0BB8_0000);
        apb(1'b1, TLO_CTRL_OFS, 32'h104);
        u_bus.put(0, 16'h079E);
        rchk("hys hold", TLO_STATE_OFS, 32'h1, 32'h1);
        u_bus.put(0, 16'h076B);
        rchk("hys clear", TLO_STATE_OFS, 32'h1, 32'h0);
        $display("teach and hysteresis done");
        // second reset in mid-run, then the register reset values
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        foreach (ofs[i])
            rchk("reset value", ofs[i], 32'hFFFF_FFFF, rst[i]);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", err, 1);
        chk("unmapped data", rd, 0);
        apb(1'b1, TLO_MEAS_OFS, 32'hFFFF_FFFF);
        rchk("read only", TLO_MEAS_OFS, 32'h1_FFFF, 32'h0);
        $display("reset and registers done");
        final_report;
    end
endmodule
`default_nettype wire
